/* File: rtl/pxb_crossbar.v */
`timescale 1ns/10ps
`include "pxb_regs.vh"
// Functional notes
// - Enabled peripherals take lowest free pin, UART first.
// - UART transmit on P0.4, receive on P0.5.
// - Assigned and skipped pins are passed over.
// - Two-wire bus and UART take both pins.
// - Leftover pins act as general-purpose pins.
// - Slave select routed only in four-wire mode.
// - Analog pin: no pull-up, driver or receiver.
// - Input kind 1 digital, 0 analog; reset digital.
// - Two-wire pins always drive open-drain.
// - Pull-ups on open-drain pins unless disabled.
// - Pull-up off while pin drives low.
// - Router disabled turns off ports 0-2.3 drivers.
// - P2.4-P2.7 and P3.0 always general purpose.
// - Route register A enables eight peripheral groups.
// - Route B bit 7 pull-up disable, bit 6 enable.
// - Route B bits 5-3 route timer and count inputs.
// - Channel count field routes channels 0 to N-1.
// - Writes latch; ordinary reads return pin levels.
// - Read-modify-write reads the latch instead.
// - Port registers have byte and bit access.
// - Drive kind 0 open-drain, 1 push-pull.
module pxb_crossbar (
  input  wire        i_mclk,       // System clock.
  input  wire        i_rstn,       // Asynchronous reset, active low.
  input  wire [7:0]  i_sfr_addr,   // Register address.
  input  wire [7:0]  i_sfr_wdata,  // Write data.
  input  wire        i_sfr_wr,     // Byte write strobe.
  input  wire        i_sfr_bitwr,  // Single-bit write strobe.
  input  wire [2:0]  i_sfr_bitsel, // Bit number for single-bit access.
  input  wire        i_sfr_rmw,    // Read is part of read-modify-write.
  output reg  [7:0]  o_sfr_rdata,  // Read data.
  input  wire [1:0]  i_slave_select_mode, // Slave select mode field.
  input  wire [15:0] i_func_out,   // Peripheral outputs per slot.
  input  wire [15:0] i_func_oe,    // Peripheral output enables per slot.
  output reg  [15:0] o_func_in,    // Pad levels delivered to each slot.
  input  wire [24:0] i_pad_in,     // Pad levels.
  output reg  [24:0] o_pad_out,    // Pad output value.
  output reg  [24:0] o_pad_oe,     // Pad driver enable.
  output reg  [24:0] o_pad_pullup, // Weak pull-up enable.
  output reg  [24:0] o_pad_rxen,   // Digital receiver enable.
  output wire [79:0] o_func_pin    // Pin index chosen per slot, 31 none.
);
  // ****************************************
  // Register file
  // ****************************************
  reg [7:0]  route_a_q;
  reg [7:0]  route_b_q;
  reg [24:0] latch_q;
  reg [24:0] inkind_q;
  reg [24:0] drvkind_q;
  reg [19:0] skip_q;
  reg [24:0] pad_s1_q;
  reg [24:0] pad_s2_q;
  reg [24:0] pad_s3_q;
  reg [24:0] pad_q;
  // Maps an address to a port byte; 5 is none. Used by write and read.
  function [2:0] port_of;
    input [7:0] a;
    begin
      case (a)
        `PXB_ADDR_P0: port_of = 3'h0;
        `PXB_ADDR_P1: port_of = 3'h1;
        `PXB_ADDR_P2: port_of = 3'h2;
        `PXB_ADDR_P3: port_of = 3'h3;
        default:      port_of = 3'h5;
      endcase
    end
  endfunction
  // Places one byte into a 25-bit vector at the given port.
  function [24:0] put_byte;
    input [24:0] v;
    input [2:0]  port;
    input [7:0]  b;
    reg   [31:0] t;
    begin
      t = {7'h00, v};
      t[port*8 +: 8] = b;
      put_byte = t[24:0];
    end
  endfunction
  wire [2:0]  wport = port_of(i_sfr_addr);
  wire [31:0] latch_w = {7'h00, latch_q};
  wire [7:0]  latch_byte = (wport < 3'h4) ? latch_w[wport*8 +: 8] : 8'h00;
  reg  [7:0]  bit_merge;
  // Single-bit writes modify the latched byte, never the pin levels.
  always @* begin
    bit_merge = latch_byte;
    bit_merge[i_sfr_bitsel] = i_sfr_wdata[0];
  end
  // Registers are written by byte or by bit; ports store into latches.
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      route_a_q <= `PXB_RST_ROUTE;
      route_b_q <= `PXB_RST_ROUTE;
      latch_q   <= {25{1'b1}};
      inkind_q  <= {25{1'b1}};
      drvkind_q <= {25{1'b0}};
      skip_q    <= {20{1'b0}};
    end else if (i_sfr_wr || i_sfr_bitwr) begin
      if (wport < 3'h4) begin
        latch_q <= put_byte(latch_q, wport,
                            i_sfr_bitwr ? bit_merge : i_sfr_wdata);
      end
      case (i_sfr_addr)
        `PXB_ADDR_ROUTE_A: route_a_q <= i_sfr_wdata;
        `PXB_ADDR_ROUTE_B: route_b_q <= i_sfr_wdata;
        `PXB_ADDR_IN0:     inkind_q[7:0]   <= i_sfr_wdata;
        `PXB_ADDR_IN1:     inkind_q[15:8]  <= i_sfr_wdata;
        `PXB_ADDR_IN2:     inkind_q[23:16] <= i_sfr_wdata;
        `PXB_ADDR_IN3:     inkind_q[24]    <= i_sfr_wdata[0];
        `PXB_ADDR_DRV0:    drvkind_q[7:0]   <= i_sfr_wdata;
        `PXB_ADDR_DRV1:    drvkind_q[15:8]  <= i_sfr_wdata;
        `PXB_ADDR_DRV2:    drvkind_q[23:16] <= i_sfr_wdata;
        `PXB_ADDR_DRV3:    drvkind_q[24]    <= i_sfr_wdata[0];
        `PXB_ADDR_SKIP0:   skip_q[7:0]   <= i_sfr_wdata;
        `PXB_ADDR_SKIP1:   skip_q[15:8]  <= i_sfr_wdata;
        `PXB_ADDR_SKIP2:   skip_q[19:16] <= i_sfr_wdata[3:0];
        default:           route_a_q <= route_a_q;
      endcase
    end
  end

  // ****************************************
  // Pad input synchronisers
  // ****************************************
  // Three stages; a change is accepted once stages two and three agree.
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pad_s1_q <= {25{1'b1}};
      pad_s2_q <= {25{1'b1}};
      pad_s3_q <= {25{1'b1}};
      pad_q    <= {25{1'b1}};
    end else begin
      pad_s1_q <= i_pad_in;
      pad_s2_q <= pad_s1_q;
      pad_s3_q <= pad_s2_q;
      pad_q    <= (pad_s2_q & pad_s3_q) | (pad_q & (pad_s2_q | pad_s3_q));
    end
  end
  // Analog pins have their receiver off and read as zero.
  wire [24:0] pin_read = pad_q & inkind_q;
  wire [31:0] pin_w    = {7'h00, pin_read};
  // Ordinary reads return pins; read-modify-write returns the latch.
  always @* begin
    case (i_sfr_addr)
      `PXB_ADDR_ROUTE_A: o_sfr_rdata = route_a_q;
      `PXB_ADDR_ROUTE_B: o_sfr_rdata = route_b_q;
      `PXB_ADDR_IN0:     o_sfr_rdata = inkind_q[7:0];
      `PXB_ADDR_IN1:     o_sfr_rdata = inkind_q[15:8];
      `PXB_ADDR_IN2:     o_sfr_rdata = inkind_q[23:16];
      `PXB_ADDR_IN3:     o_sfr_rdata = {7'h00, inkind_q[24]};
      `PXB_ADDR_DRV0:    o_sfr_rdata = drvkind_q[7:0];
      `PXB_ADDR_DRV1:    o_sfr_rdata = drvkind_q[15:8];
      `PXB_ADDR_DRV2:    o_sfr_rdata = drvkind_q[23:16];
      `PXB_ADDR_DRV3:    o_sfr_rdata = {7'h00, drvkind_q[24]};
      `PXB_ADDR_SKIP0:   o_sfr_rdata = skip_q[7:0];
      `PXB_ADDR_SKIP1:   o_sfr_rdata = skip_q[15:8];
      `PXB_ADDR_SKIP2:   o_sfr_rdata = {4'h0, skip_q[19:16]};
      default: begin
        if (wport < 3'h4) begin
          o_sfr_rdata = i_sfr_rmw ? latch_byte : pin_w[wport*8 +: 8];
        end else begin
          o_sfr_rdata = 8'h00;
        end
      end
    endcase
  end

  // ****************************************
  // Priority allocation
  // ****************************************
  // Slots: 0 uart tx, 1 uart rx, 2 sck, 3 miso, 4 mosi, 5 nss, 6 sda, 7 scl,
  // 8 sysclk, 9 cmp0, 10 cmp0 async, 11 cmp1, 12 cmp1 async, 13 t0, 14 t1,
  // 15 count input. Channel slots follow the fixed slots in a second pass.
  wire       en   = route_b_q[`PXB_B_ENABLE];
  wire       uart = route_a_q[`PXB_A_UART];
  wire       spi  = route_a_q[`PXB_A_SPI];
  wire       twi  = route_a_q[`PXB_A_TWOWIRE];
  wire [2:0] chan = route_b_q[`PXB_B_CHAN_HI:`PXB_B_CHAN_LO];
  // Reserved channel codes route nothing.
  wire [2:0] nchan = (chan > 3'h5) ? 3'h0 : chan;
  wire [15:0] req;
  assign req[1:0]   = 2'b00;                             // UART placed directly.
  assign req[4:2]   = {3{spi}};
  assign req[5]     = spi & (i_slave_select_mode != 2'b00);
  assign req[7:6]   = {2{twi}};
  assign req[8]     = route_a_q[`PXB_A_SYSCLK];
  assign req[9]     = route_a_q[`PXB_A_CMP0];
  assign req[10]    = route_a_q[`PXB_A_CMP0A];
  assign req[11]    = route_a_q[`PXB_A_CMP1];
  assign req[12]    = route_a_q[`PXB_A_CMP1A];
  assign req[13]    = route_b_q[`PXB_B_TIMER0];
  assign req[14]    = route_b_q[`PXB_B_TIMER1];
  assign req[15]    = 1'b0;
  // UART pins are fixed and taken out of the pool before the walk.
  wire [19:0] uart_pins = {14'h0000, uart, uart, 4'h0};
  wire [19:0] taken = skip_q | uart_pins;
  wire [79:0] slot;
  pxb_alloc u_alloc (
    .i_req   (req),
    .i_taken (taken),
    .o_slot  (slot)
  );
  // Count input and channels come after in priority; a second pass with
  // everything the first pass used removed.
  reg  [19:0] used1;
  integer     k;
  always @* begin
    used1 = taken;
    for (k = 2; k < 15; k = k + 1) begin
      if (req[k]) begin
        used1[slot[k*5 +: 5]] = 1'b1;
      end
    end
  end
  wire [15:0] req2 = {10'h000, nchan > 3'h4, nchan > 3'h3, nchan > 3'h2,
                      nchan > 3'h1, nchan > 3'h0, route_b_q[`PXB_B_COUNT]};
  wire [79:0] slot2;
  pxb_alloc u_alloc2 (
    .i_req   (req2),
    .i_taken (used1),
    .o_slot  (slot2)
  );
  // Slot table out: count input in slot 15; channel pins stay in slot2, not reported.
  assign o_func_pin = {slot2[4:0], slot[74:10],
                       uart ? 5'd5 : 5'd31, uart ? 5'd4 : 5'd31};

  // ****************************************
  // Pad control
  // ****************************************
  reg [19:0] owned;
  reg [19:0] fout;
  reg [19:0] foe;
  reg [19:0] opendr;
  reg [4:0]  pn;
  integer    j;
  // Gather which pins a peripheral drives; channels reuse the i_func_out bits of slots 0-4.
  always @* begin
    owned  = uart_pins;
    fout   = 20'h00000;
    foe    = 20'h00000;
    opendr = 20'h00000;
    o_func_in = 16'h0000;
    fout[`PXB_UART_TX_PIN] = i_func_out[0];
    foe[`PXB_UART_TX_PIN]  = uart & i_func_oe[0];
    o_func_in[1] = pad_q[`PXB_UART_RX_PIN];
    for (j = 2; j < 15; j = j + 1) begin
      pn = slot[j*5 +: 5];
      if (req[j]) begin
        owned[pn]    = 1'b1;
        fout[pn]     = i_func_out[j];
        foe[pn]      = i_func_oe[j];
        opendr[pn]   = (j == 6) || (j == 7);
        o_func_in[j] = pad_q[pn];
      end
    end
    for (j = 0; j < 6; j = j + 1) begin
      pn = slot2[j*5 +: 5];
      if (req2[j]) begin
        owned[pn] = 1'b1;
        if (j == 0) begin
          o_func_in[15] = pad_q[pn];
        end else begin
          fout[pn] = i_func_out[j - 1];
          foe[pn]  = 1'b1;
        end
      end
    end
  end
  // Per-pin driver, pull-up and receiver decisions.
  genvar g;
  generate
    for (g = 0; g < 25; g = g + 1) begin : g_pad
      wire xpin  = (g < `PXB_XPINS);
      wire dig   = inkind_q[g];
      wire mine  = xpin && en && owned[g];
      wire val   = mine ? fout[g] : latch_q[g];
      wire drive = mine ? foe[g] : 1'b1;
      wire pp    = drvkind_q[g] && !(mine && opendr[g]);
      wire live  = dig && (!xpin || en);
      always @* begin
        o_pad_out[g]    = val;
        // Open-drain pins drive only the low level.
        o_pad_oe[g]     = live && drive && (pp || !val);
        // Pull-up only on open-drain, enabled, not driving low.
        o_pad_pullup[g] = dig && !pp && !route_b_q[`PXB_B_PULLDIS]
                          && !(o_pad_oe[g] && !val);
        o_pad_rxen[g]   = dig;
      end
    end
  endgenerate
endmodule // pxb_crossbar

/* File: rtl/pxb_regs.vh */
`ifndef PXB_REGS_VH
`define PXB_REGS_VH
// Register addresses on the special function register port.
`define PXB_ADDR_ROUTE_A   8'he1
`define PXB_ADDR_ROUTE_B   8'he2
`define PXB_ADDR_P0        8'h80
`define PXB_ADDR_P1        8'h90
`define PXB_ADDR_P2        8'ha0
`define PXB_ADDR_P3        8'hb0
`define PXB_ADDR_IN0       8'hf1
`define PXB_ADDR_IN1       8'hf2
`define PXB_ADDR_IN2       8'hf3
`define PXB_ADDR_IN3       8'hf4
`define PXB_ADDR_DRV0      8'ha4
`define PXB_ADDR_DRV1      8'ha5
`define PXB_ADDR_DRV2      8'ha6
`define PXB_ADDR_DRV3      8'ha7
`define PXB_ADDR_SKIP0     8'hd4
`define PXB_ADDR_SKIP1     8'hd5
`define PXB_ADDR_SKIP2     8'hd6
// Reset values.
`define PXB_RST_ROUTE      8'h00
`define PXB_RST_LATCH      8'hff
`define PXB_RST_INKIND     8'hff
`define PXB_RST_DRVKIND    8'h00
`define PXB_RST_SKIP       8'h00
// Field positions in route register A.
`define PXB_A_UART         0
`define PXB_A_SPI          1
`define PXB_A_TWOWIRE      2
`define PXB_A_SYSCLK       3
`define PXB_A_CMP0         4
`define PXB_A_CMP0A        5
`define PXB_A_CMP1         6
`define PXB_A_CMP1A        7
// Field positions in route register B.
`define PXB_B_CHAN_LO      0
`define PXB_B_CHAN_HI      2
`define PXB_B_COUNT        3
`define PXB_B_TIMER0       4
`define PXB_B_TIMER1       5
`define PXB_B_ENABLE       6
`define PXB_B_PULLDIS      7
// Crossbar geometry.
`define PXB_XPINS          20
`define PXB_NFUNC          16
`define PXB_UART_TX_PIN    4
`define PXB_UART_RX_PIN    5
`endif

/* File: rtl/pxb_alloc.v */
`timescale 1ns/10ps
`include "pxb_regs.vh"
// Priority allocator: each requested slot takes the lowest pin that is free.
module pxb_alloc (
  input  wire [15:0] i_req,    // Slot requests in priority order, bit 0 first.
  input  wire [19:0] i_taken,  // Pins skipped or already fixed.
  output reg  [79:0] o_slot    // Pin index per slot, 5 bits each, 31 when none.
);
  integer s;
  integer p;
  reg [19:0] used;
  reg        found;
  // Walk the slots in order, each scanning for the lowest unused pin.
  always @* begin
    used   = i_taken;
    o_slot = {80{1'b1}};
    for (s = 0; s < `PXB_NFUNC; s = s + 1) begin
      found = 1'b0;
      for (p = 0; p < `PXB_XPINS; p = p + 1) begin
        if (i_req[s] && !found && !used[p]) begin
          found            = 1'b1;
          used[p]          = 1'b1;
          o_slot[s*5 +: 5] = p[4:0];
        end
      end
    end
  end
endmodule // pxb_alloc

/* File: verif/pxb_monitor.sv */
`timescale 1ns/10ps
// ****
// Pad and register checks
// ****
module pxb_monitor (
  input wire        i_mclk,       // Clock.
  input wire        i_rstn,       // Reset.
  input wire [7:0]  i_sfr_addr,   // Address.
  input wire [7:0]  i_sfr_wdata,  // Write data.
  input wire        i_sfr_wr,     // Byte write.
  input wire        i_sfr_bitwr,  // Bit write.
  input wire        i_sfr_rmw,    // Latch read.
  input wire [7:0]  o_sfr_rdata,  // Read data.
  input wire [24:0] i_pad_in,     // Pad levels.
  input wire [24:0] o_pad_out,    // Pad value.
  input wire [24:0] o_pad_oe,     // Pad enable.
  input wire [24:0] o_pad_pullup, // Pull-ups.
  input wire [24:0] o_pad_rxen,   // Receivers.
  input wire [79:0] o_func_pin    // Slot pins.
);
  logic       bad_pin;
  logic       od_bad;
  wire  [4:0] sda = o_func_pin[34:30];
  wire  [4:0] scl = o_func_pin[39:35];
  // Flags slots on pins the router never owns, and two-wire pins driven high.
  always_comb begin
    bad_pin = 1'b0;
    for (int s = 0; s < 16; s++)
      if (o_func_pin[s*5+:5] > 5'd19 && o_func_pin[s*5+:5] != 5'd31)
        bad_pin = 1'b1;
    od_bad = (sda < 5'd20 && o_pad_oe[sda] && o_pad_out[sda]) ||
             (scl < 5'd20 && o_pad_oe[scl] && o_pad_out[scl]);
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence s_wr(a);
    i_sfr_wr && i_sfr_addr == a;
  endsequence
  // Pad reads pass a synchroniser, so the pins must hold still first.
  sequence s_steady;
    i_sfr_addr == 8'h80 && !i_sfr_rmw && o_pad_rxen[7:0] == 8'hff && $stable(i_pad_in[7:0]);
  endsequence
  AST_ANALOG_OFF: assert property ((~o_pad_rxen & (o_pad_pullup | o_pad_oe)) == 25'h0)
    else $error("analog pin still active");
  AST_LOW_NO_PULL: assert property ((o_pad_oe & ~o_pad_out & o_pad_pullup) == 25'h0)
    else $error("pull-up on a low pin");
  AST_PULL_DIS: assert property (s_wr(8'he2) ##0 i_sfr_wdata[7] |=> o_pad_pullup == 25'h0)
    else $error("pull-up left on");
  AST_ROUTER_OFF: assert property (s_wr(8'he2) ##0 !i_sfr_wdata[6] |=> o_pad_oe[19:0] == 0)
    else $error("driver on with router off");
  AST_GPIO_ONLY: assert property (!bad_pin)
    else $error("slot on a plain port pin");
  AST_UART_FIXED: assert property (s_wr(8'he1) ##0 i_sfr_wdata[0] |=> o_func_pin[9:0] == 10'h0a4)
    else $error("uart pins moved");
  AST_TWOWIRE_OD: assert property (!od_bad)
    else $error("two-wire pin driven high");
  AST_RMW_LATCH: assert property (s_wr(8'h80) ##1 (i_sfr_addr == 8'h80 && i_sfr_rmw && !i_sfr_wr
    && !i_sfr_bitwr) |-> o_sfr_rdata == $past(i_sfr_wdata))
    else $error("latch read wrong");
  AST_ANALOG_READ: assert property (i_sfr_addr == 8'h80 && !i_sfr_rmw |->
    (o_sfr_rdata & ~o_pad_rxen[7:0]) == 8'h00)
    else $error("analog pin read high");
  AST_PIN_READ: assert property (s_steady [*8] |-> o_sfr_rdata == i_pad_in[7:0])
    else $error("pin read wrong");
endmodule // pxb_monitor
bind pxb_crossbar pxb_monitor u_mon (.i_mclk, .i_rstn, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr,
  .i_sfr_bitwr, .i_sfr_rmw, .o_sfr_rdata, .i_pad_in, .o_pad_out, .o_pad_oe, .o_pad_pullup,
  .o_pad_rxen, .o_func_pin);

/* File: verif/pxb_pad_model.sv */
`timescale 1ns/10ps
// ****
// Board side of the pads
// ****
module pxb_pad_model (
  input  wire [24:0] i_pad_out, // Driven value.
  input  wire [24:0] i_pad_oe,  // Driver enables.
  input  wire [24:0] i_ext,     // Board level.
  output wire [24:0] o_pad_in   // Pad level.
);
  // The board always drives idle pads, so no pad floats to a guessed level.
  assign o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext);
endmodule // pxb_pad_model

/* File: verif/tb.sv */
`timescale 1ns/10ps
module tb;
  logic        i_mclk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [7:0]  i_sfr_addr = 8'h00;
  logic [7:0]  i_sfr_wdata = 8'h00;
  logic        i_sfr_wr = 1'b0;
  logic        i_sfr_bitwr = 1'b0;
  logic [2:0]  i_sfr_bitsel = 3'd0;
  logic        i_sfr_rmw = 1'b0;
  logic [1:0]  i_slave_select_mode = 2'd0;
  logic [15:0] i_func_out = 16'h0;
  logic [15:0] i_func_oe = 16'hfffd;
  logic [24:0] ext = 25'h0;
  logic [7:0]  o_sfr_rdata;
  logic [15:0] o_func_in;
  logic [24:0] i_pad_in, o_pad_out, o_pad_oe, o_pad_pullup, o_pad_rxen;
  logic [79:0] o_func_pin;
  logic [31:0] seed = 32'd53110;
  int          failures = 0;
  int          comparisons = 0;
  // ****
  // Clock, design and board
  // ****
  always #20 i_mclk = ~i_mclk;
  pxb_crossbar u_dut (.i_mclk, .i_rstn, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .i_sfr_bitwr,
    .i_sfr_bitsel, .i_sfr_rmw, .o_sfr_rdata, .i_slave_select_mode, .i_func_out, .i_func_oe,
    .o_func_in, .i_pad_in, .o_pad_out, .o_pad_oe, .o_pad_pullup, .o_pad_rxen, .o_func_pin);
  pxb_pad_model u_pads (.i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe), .i_ext(ext),
    .o_pad_in(i_pad_in));
  // ****
  // Helpers
  // ****
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Lowest free pin per slot; uart sits on pins 4 and 5 whatever the skips say.
  function automatic logic [79:0] exp_pins(logic [7:0] ra, rb, logic [19:0] sk, logic [1:0] sm);
    logic [15:0] en;
    logic [19:0] tk;
    logic [79:0] r;
    int          p;
    en = {rb[3], rb[5], rb[4], ra[7:3], {2{ra[2]}}, ra[1] && sm != 0, {3{ra[1]}}, {2{ra[0]}}};
    tk = sk | (ra[0] ? 20'h30 : 20'h0);
    r = {16{5'd31}};
    if (ra[0])
      r[9:0] = 10'h0a4;
    for (int s = 2; s < 16; s++) begin
      p = 0;
      while (p < 20 && tk[p])
        p++;
      if (en[s] && p < 20) begin
        tk[p] = 1'b1;
        r[s*5+:5] = p[4:0];
      end
    end
    return r;
  endfunction
  task automatic chk(input string n, input logic [79:0] e, input logic [79:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  // Write ends one settle step after the taking edge so outputs can be read.
  task automatic acc(input logic [7:0] a, d, input logic b = 1'b0, input logic [2:0] s = 3'd0);
    @(posedge i_mclk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= !b;
    i_sfr_bitwr <= b;
    i_sfr_bitsel <= s;
    i_sfr_rmw <= 1'b0;
    @(posedge i_mclk);
    i_sfr_wr <= 1'b0;
    i_sfr_bitwr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
    i_sfr_addr <= a;
    i_sfr_rmw <= m;
    @(posedge i_mclk);
    #1 d = o_sfr_rdata;
  endtask
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    logic [7:0]  v, ra, rb;
    logic [19:0] sk;
    logic [19:0] tk;
    int          n;
    int          p;
    logic [31:0] x;
    logic [79:0] e;
    logic [7:0]  ad [11] = '{8'he1, 8'he2, 8'hf1, 8'hf2, 8'hf3, 8'ha4, 8'ha5, 8'ha6, 8'hd4,
                             8'h80, 8'h55};
    repeat (16) @(posedge i_mclk);
    i_rstn <= 1'b1;
    chk("oe", 25'h0, o_pad_oe);
    chk("pullup", 5'h1f, o_pad_pullup[24:20]);
    foreach (ad[i]) begin
      rd(ad[i], 1'b1, v);
      chk("reset", (ad[i][7:4] == 4'hf || ad[i] == 8'h80) ? 8'hff : 8'h00, v);
    end
    x = rnd();
    ext <= {17'h0, x[7:0]};
    acc(8'h80, ~x[7:0]);
    rd(8'h80, 1'b1, v);
    chk("latch", {72'h0, ~x[7:0]}, v);
    e = {72'h0, ~x[7:0]};
    e[x[11:9]] = x[8];
    acc(8'h80, {7'h0, x[8]}, 1'b1, x[11:9]);
    rd(8'h80, 1'b1, v);
    chk("bit", e, v);
    repeat (9) rd(8'h80, 1'b0, v);
    chk("pins", x[7:0], v);
    acc(8'hf1, 8'h0f);
    rd(8'h80, 1'b0, v);
    chk("analog", 4'h0, v[7:4]);
    chk("rx", 12'h0, {o_pad_rxen[7:4], o_pad_pullup[7:4], o_pad_oe[7:4]});
    acc(8'hd4, 8'hf0);
    acc(8'hf1, 8'hff);
    acc(8'ha6, 8'hff);
    acc(8'ha0, x[15:8]);
    chk("gpio", {4'hf, x[15:12], 4'h0},
        {o_pad_oe[23:20], o_pad_out[23:20], o_pad_pullup[23:20]});
    acc(8'ha4, 8'hff);
    acc(8'ha5, 8'hff);
    // Random routings with route A all-enabled and all-skipped corners first.
    for (int k = 0; k < 6; k++) begin
      x = rnd();
      ra = (k == 0) ? 8'hff : x[7:0];
      sk = (k == 0) ? 20'h0 : (k == 1) ? 20'hfffff : x[31:12];
      rb = {x[8] | (k == 0), 1'b1, x[11:9], x[2:0]};
      i_slave_select_mode <= x[13:12];
      i_func_out <= x[31:16];
      acc(8'hd4, sk[7:0]);
      acc(8'hd5, sk[15:8]);
      acc(8'hd6, {4'h0, sk[19:16]});
      acc(8'he1, ra);
      acc(8'he2, rb);
      e = exp_pins(ra, rb, sk, x[13:12]);
      chk("func_pin", e, o_func_pin);
      for (int s = 0; s < 13; s++)
        if (s inside {0, 2, 4, [8:12]} && e[s*5+:5] < 20)
          chk("drive", {1'b1, i_func_out[s]}, {o_pad_oe[e[s*5+:5]], o_pad_out[e[s*5+:5]]});
      // Channels take the lowest pins left after every fixed slot; reserved codes route none.
      tk = sk | (ra[0] ? 20'h30 : 20'h0);
      for (int s = 2; s < 16; s++)
        if (e[s*5+:5] < 20)
          tk[e[s*5+:5]] = 1'b1;
      n = (rb[2:0] > 3'd5) ? 0 : rb[2:0];
      for (int c = 0; c < n; c++) begin
        p = 0;
        while (p < 20 && tk[p])
          p++;
        if (p < 20) begin
          tk[p] = 1'b1;
          chk("chan", {1'b1, i_func_out[c]}, {o_pad_oe[p], o_pad_out[p]});
        end
      end
      if (ra[0]) begin
        ext[5] <= x[14];
        repeat (8) @(posedge i_mclk);
        #1 chk("uart_rx", x[14], o_func_in[1]);
      end
      acc(8'he2, rb & 8'hbf);
      chk("off", 20'h0, o_pad_oe[19:0]);
      if (rb[7])
        chk("pud", 25'h0, o_pad_pullup);
    end
    summarize();
  end
  // Guard against a hung run.
  initial begin
    repeat (20000) @(posedge i_mclk);
    failures++;
    summarize();
  end
endmodule // tb
